// *** link_pkg.sv ***
// Shared constants and types for the modem setup command parser and its host end
// Behaviour
// - Commands arrive on the payload serial input
// - 9600 baud 8N1, one or two stops
// - Select low disables radio payload traffic
// - Program mode echoes every received character
// - Only defined command strings change anything
// - Carriage return 0x0d executes a command
// - Address digit selects one of eight
// - Payload only with matching link address
// - Volatile address reloads non-volatile default zero; reset loads ADDR_RESET into addr and nv_addr alike
// - Store command copies address, channel to nonvolatile
// - Tilde sent when nonvolatile write completes
// - Tone commands key carrier; bare return off
// - Select high resumes normal link operation
// - Pending flag warns only, never stops input
// - Host may use pending rising edge
// - Enable held low without terminal-ready
// - Pending high while receive buffer holds data
package link_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int BAUD = 9600;
	localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD);
	localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD / 2);
	localparam int TONE_LO_HZ = 8000;
	localparam int TONE_HI_HZ = 16000;
	localparam logic [11:0] LO_HALF_CYC = 12'(CLK_HZ / TONE_LO_HZ / 2);
	localparam logic [11:0] HI_HALF_CYC = 12'(CLK_HZ / TONE_HI_HZ / 2);
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_TILDE = 8'h7e;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [2:0] ADDR_RESET = 3'h0;
	localparam logic [3:0] CHAN_RESET = 4'h0;
	localparam int CMD_LEN = 10;
	// Command texts as packed characters, first character in the highest byte
	localparam logic [CMD_LEN*8-1:0] SET_LINK_ADDRESS_CMD = 80'h41444452;
	localparam logic [CMD_LEN*8-1:0] STORE_DEFAULTS_CMD = 80'h53455450524f4752414d;
	localparam logic [CMD_LEN*8-1:0] CARRIER_ONLY_CMD = 80'h4e4f544f4e45;
	localparam logic [CMD_LEN*8-1:0] LOW_TONE_CMD = 80'h4c46544f4e45;
	localparam logic [CMD_LEN*8-1:0] HIGH_TONE_CMD = 80'h4846544f4e45;
	localparam logic [15:0] NV_WRITE_CYC = 16'h0fa0;
	typedef enum logic [1:0] {TONE_OFF = 2'b00, TONE_CARRIER = 2'b01,
		TONE_LOW = 2'b10, TONE_HIGH = 2'b11} tone_t;
	typedef enum logic [1:0] {SER_IDLE = 2'b00, SER_START = 2'b01,
		SER_DATA = 2'b10, SER_STOP = 2'b11} ser_t;
endpackage

// *** host_link_if.sv ***
`timescale 1ns/1ps
// Serial and control wires between host UART and modem
interface host_link_if;
	logic host_serial_in;
	logic echo_serial_out;
	logic program_sel_n;
	logic enable_n;
	logic rx_pending;
	modport modem (input host_serial_in, input program_sel_n, input enable_n,
		output echo_serial_out, output rx_pending);
	modport host (output host_serial_in, output program_sel_n, output enable_n,
		input echo_serial_out, input rx_pending);
endinterface // host_link_if

// *** byte_fifo.sv ***
`timescale 1ns/1ps
// Flip-flop FIFO with valid/ready on both sides
module byte_fifo
	import link_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, rd_r;
	logic [AW:0] cnt_r;
	logic push, pop;
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
			begin
				mem_r[wr_r] <= in_data;
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop)
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // byte_fifo

// *** modem_setup_command_parser.sv ***
`timescale 1ns/1ps
// Modem end: serial receive, echo, setup command parser and received-data pending flag
module modem_setup_command_parser
	import link_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter logic [15:0] NV_CYC = NV_WRITE_CYC,
	parameter logic [11:0] BIT_T = BIT_CYC
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Host link
	host_link_if.modem link,
	// Radio side
	input wire logic radio_rx_valid,
	input wire logic [7:0] radio_rx_data,
	input wire logic [2:0] radio_rx_addr,
	output logic radio_enable,
	output logic [1:0] tone_mode,
	output logic tone_out,
	output logic [2:0] link_addr,
	output logic [3:0] link_chan,
	output logic nv_busy
);
	typedef struct packed {
		ser_t rs;
		logic [11:0] rcnt;
		logic [2:0] rbit;
		logic [7:0] rsh;
		ser_t ts;
		logic [11:0] tcnt;
		logic [2:0] tbit;
		logic [7:0] tsh;
		logic txo;
		logic [CMD_LEN*8-1:0] cbuf;
		logic [3:0] clen;
		logic ovf;
		logic [2:0] addr;
		logic [3:0] chan;
		logic [2:0] nv_addr;
		logic [3:0] nv_chan;
		logic [15:0] nvcnt;
		logic nvb;
		logic tilde;
		tone_t tone;
		logic [11:0] tonecnt;
		logic toneo;
		logic radio_en;
		logic pend;
	} st_t;
	st_t s_r, s_nxt;
	logic fifo_in_ready, fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_pop, rx_done, prog;
	logic [7:0] rx_byte;
	logic [7:0] rx_in_data;
	logic rx_in_valid;
	assign prog = !link.program_sel_n && !link.enable_n;
	// Radio payload kept only for our address, and only outside setup
	assign rx_in_valid = radio_rx_valid && s_r.radio_en && (radio_rx_addr == s_r.addr);
	assign rx_in_data = radio_rx_data;
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_byte_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(rx_in_valid),
		.in_data(rx_in_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(fifo_pop)
	);
	// Drain buffered payload to the host only when transmitter idle and not in setup
	// A pending tilde holds the queue so a popped byte is never lost
	assign fifo_pop = fifo_valid && s_r.ts == SER_IDLE && !prog && !rx_done && !s_r.tilde;
	assign rx_done = (s_r.rs == SER_STOP) && (s_r.rcnt == BIT_T - 12'h1);
	assign rx_byte = s_r.rsh;
	always_comb
	begin
		logic tx_go;
		logic [7:0] tx_byte;
		tx_go = 1'b0;
		tx_byte = 8'h00;
		s_nxt = s_r;
		// Receiver: start detect, mid-bit sampling; a second stop bit is just idle line
		unique case (s_r.rs)
			SER_IDLE:
			begin
				s_nxt.rcnt = '0;
				if (!link.host_serial_in)
					s_nxt.rs = SER_START;
			end
			SER_START:
			begin
				s_nxt.rcnt = s_r.rcnt + 12'h1;
				if (s_r.rcnt == (BIT_T >> 1))
				begin
					s_nxt.rcnt = '0;
					s_nxt.rbit = '0;
					s_nxt.rs = link.host_serial_in ? SER_IDLE : SER_DATA;
				end
			end
			SER_DATA:
			begin
				s_nxt.rcnt = s_r.rcnt + 12'h1;
				if (s_r.rcnt == BIT_T - 12'h1)
				begin
					s_nxt.rcnt = '0;
					s_nxt.rsh = {link.host_serial_in, s_r.rsh[7:1]};
					s_nxt.rbit = s_r.rbit + 3'h1;
					if (s_r.rbit == 3'h7)
						s_nxt.rs = SER_STOP;
				end
			end
			SER_STOP:
			begin
				s_nxt.rcnt = s_r.rcnt + 12'h1;
				if (rx_done)
					s_nxt.rs = SER_IDLE;
			end
		endcase
		// Command parsing in setup mode
		if (rx_done && prog)
		begin
			tx_go = 1'b1;
			tx_byte = rx_byte;
			if (rx_byte == CH_CR)
			begin
				if (!s_r.ovf)
				begin
					// Only exact strings act; anything else is dropped silently
					if (s_r.clen == 4'h0)
						s_nxt.tone = TONE_OFF;
					else if (s_r.cbuf == CARRIER_ONLY_CMD)
						s_nxt.tone = TONE_CARRIER;
					else if (s_r.cbuf == LOW_TONE_CMD)
						s_nxt.tone = TONE_LOW;
					else if (s_r.cbuf == HIGH_TONE_CMD)
						s_nxt.tone = TONE_HIGH;
					else if (s_r.cbuf == STORE_DEFAULTS_CMD && !s_r.nvb)
					begin
						s_nxt.nvb = 1'b1;
						s_nxt.nvcnt = '0;
					end
					else if (s_r.clen == 4'h5 && s_r.cbuf[39:8] == SET_LINK_ADDRESS_CMD[31:0]
						&& s_r.cbuf[7:3] == CH_ZERO[7:3])
						s_nxt.addr = s_r.cbuf[2:0];
				end
				s_nxt.cbuf = '0;
				s_nxt.clen = '0;
				s_nxt.ovf = 1'b0;
			end
			else if (s_r.clen == 4'(CMD_LEN))
				s_nxt.ovf = 1'b1;
			else
			begin
				s_nxt.cbuf = {s_r.cbuf[CMD_LEN*8-9:0], rx_byte};
				s_nxt.clen = s_r.clen + 4'h1;
			end
		end
		if (!prog)
		begin
			s_nxt.tone = TONE_OFF;
			s_nxt.cbuf = '0;
			s_nxt.clen = '0;
			s_nxt.ovf = 1'b0;
		end
		// Tilde waits for the transmitter; echo has priority
		if (!tx_go && s_r.tilde && s_r.ts == SER_IDLE)
		begin
			tx_go = 1'b1;
			tx_byte = CH_TILDE;
			s_nxt.tilde = 1'b0;
		end
		else if (!tx_go && fifo_pop)
		begin
			tx_go = 1'b1;
			tx_byte = fifo_data;
		end
		// Non-volatile write model: latch values after a fixed write time;
		// it follows the send so a new completion wins over the clear
		if (s_r.nvb)
		begin
			s_nxt.nvcnt = s_r.nvcnt + 16'h1;
			if (s_r.nvcnt == NV_CYC - 16'h1)
			begin
				s_nxt.nv_addr = s_r.addr;
				s_nxt.nv_chan = s_r.chan;
				s_nxt.nvb = 1'b0;
				s_nxt.tilde = 1'b1;
			end
		end
		// Transmitter: one stop bit; an echo arriving mid-frame restarts the frame
		unique case (s_r.ts)
			SER_IDLE:
			begin
				s_nxt.txo = 1'b1;
				s_nxt.tcnt = '0;
			end
			SER_START, SER_DATA, SER_STOP:
			begin
				s_nxt.tcnt = s_r.tcnt + 12'h1;
				if (s_r.tcnt == BIT_T - 12'h1)
				begin
					s_nxt.tcnt = '0;
					if (s_r.ts == SER_START)
					begin
						s_nxt.ts = SER_DATA;
						s_nxt.txo = s_r.tsh[0];
						s_nxt.tbit = '0;
					end
					else if (s_r.ts == SER_DATA && s_r.tbit != 3'h7)
					begin
						s_nxt.tbit = s_r.tbit + 3'h1;
						s_nxt.txo = s_r.tsh[s_r.tbit + 3'h1];
					end
					else if (s_r.ts == SER_DATA)
					begin
						s_nxt.ts = SER_STOP;
						s_nxt.txo = 1'b1;
					end
					else
						s_nxt.ts = SER_IDLE;
				end
			end
		endcase
		if (tx_go)
		begin
			s_nxt.ts = SER_START;
			s_nxt.tsh = tx_byte;
			s_nxt.tcnt = '0;
			s_nxt.txo = 1'b0;
		end
		// Tone generator
		s_nxt.tonecnt = s_r.tonecnt + 12'h1;
		if ((s_r.tone == TONE_LOW && s_r.tonecnt >= LO_HALF_CYC - 12'h1)
			|| (s_r.tone == TONE_HIGH && s_r.tonecnt >= HI_HALF_CYC - 12'h1))
		begin
			s_nxt.tonecnt = '0;
			s_nxt.toneo = !s_r.toneo;
		end
		if (s_r.tone == TONE_OFF || s_r.tone == TONE_CARRIER)
		begin
			s_nxt.tonecnt = '0;
			s_nxt.toneo = 1'b0;
		end
		s_nxt.radio_en = !prog && !link.enable_n;
		// Pending flag is only a warning; reception never stalls on it
		s_nxt.pend = fifo_valid || rx_in_valid;
	end
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			s_r <= '0;
			s_r.rs <= SER_IDLE;
			s_r.ts <= SER_IDLE;
			s_r.txo <= 1'b1;
			s_r.tone <= TONE_OFF;
			s_r.addr <= ADDR_RESET;
			s_r.chan <= CHAN_RESET;
			s_r.nv_addr <= ADDR_RESET;
			s_r.nv_chan <= CHAN_RESET;
		end
		else
			s_r <= s_nxt;
	end
	assign link.echo_serial_out = s_r.txo;
	assign link.rx_pending = s_r.pend;
	assign radio_enable = s_r.radio_en;
	assign tone_mode = s_r.tone;
	assign tone_out = s_r.toneo;
	assign link_addr = s_r.addr;
	assign link_chan = s_r.chan;
	assign nv_busy = s_r.nvb;
endmodule // modem_setup_command_parser

// *** host_uart_end.sv ***
`timescale 1ns/1ps
// Host end: 8N1 or 8N2 UART transmitter, 8N1 receiver, setup select and enable drive
module host_uart_end
	import link_pkg::*;
#(
	parameter logic [11:0] BIT_T = BIT_CYC
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Host link
	host_link_if.host link,
	// User side
	input wire logic send_valid,
	input wire logic [7:0] send_data,
	output logic send_ready,
	input wire logic setup_req,
	input wire logic two_stop,
	output logic recv_valid,
	output logic [7:0] recv_data,
	output logic pending_rise
);
	typedef struct packed {
		logic [3:0] tb;
		logic [11:0] tc;
		logic [9:0] tsh;
		logic busy;
		logic txo;
		logic [3:0] rb;
		logic [11:0] rc;
		logic [8:0] rsh;
		logic rbusy;
		logic rv;
		logic [7:0] rd;
		logic pend_d;
		logic prise;
		logic sel_n;
	} hs_t;
	hs_t h_r, h_nxt;
	always_comb
	begin
		h_nxt = h_r;
		h_nxt.rv = 1'b0;
		// Frame: start, 8 data, one or two stops
		if (!h_r.busy && send_valid)
		begin
			h_nxt.busy = 1'b1;
			h_nxt.tsh = {1'b1, send_data, 1'b0};
			h_nxt.tb = two_stop ? 4'hb : 4'ha;
			h_nxt.tc = '0;
		end
		else if (h_r.busy)
		begin
			h_nxt.txo = h_r.tsh[0];
			h_nxt.tc = h_r.tc + 12'h1;
			if (h_r.tc == BIT_T - 12'h1)
			begin
				h_nxt.tc = '0;
				h_nxt.tsh = {1'b1, h_r.tsh[9:1]};
				h_nxt.tb = h_r.tb - 4'h1;
				if (h_r.tb == 4'h1)
					h_nxt.busy = 1'b0;
			end
		end
		else
			h_nxt.txo = 1'b1;
		if (!h_r.rbusy)
		begin
			h_nxt.rc = '0;
			if (!link.echo_serial_out)
			begin
				h_nxt.rbusy = 1'b1;
				h_nxt.rb = 4'h0;
			end
		end
		else
		begin
			h_nxt.rc = h_r.rc + 12'h1;
			if (h_r.rc == (h_r.rb == 4'h0 ? (BIT_T >> 1) : BIT_T - 12'h1))
			begin
				h_nxt.rc = '0;
				h_nxt.rb = h_r.rb + 4'h1;
				h_nxt.rsh = {link.echo_serial_out, h_r.rsh[8:1]};
				if (h_r.rb == 4'h9)
				begin
					h_nxt.rbusy = 1'b0;
					h_nxt.rv = link.echo_serial_out;
					h_nxt.rd = h_r.rsh[8:1];
				end
			end
		end
		// Rising edge of the pending flag can start a drain routine
		h_nxt.pend_d = link.rx_pending;
		h_nxt.prise = link.rx_pending && !h_r.pend_d;
		h_nxt.sel_n = !setup_req;
	end
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			h_r <= '0;
			h_r.txo <= 1'b1;
			h_r.sel_n <= 1'b1;
		end
		else
			h_r <= h_nxt;
	end
	assign link.host_serial_in = h_r.txo;
	assign link.program_sel_n = h_r.sel_n;
	assign link.enable_n = 1'b0;
	assign send_ready = !h_r.busy;
	assign recv_valid = h_r.rv;
	assign recv_data = h_r.rd;
	assign pending_rise = h_r.prise;
endmodule // host_uart_end

// *** modem_setup_command_parser_props.sv ***
`timescale 1ns/1ps
// Framing and mode checks on the wires between host end and modem end
module modem_setup_command_parser_props
	import link_pkg::*;
#(
	parameter logic [11:0] BIT_T = BIT_CYC
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Link wires
	input wire logic host_serial_in,
	input wire logic echo_serial_out,
	input wire logic program_sel_n,
	input wire logic enable_n,
	input wire logic rx_pending
);
	localparam int MID = int'(BIT_T >> 1);
	localparam int STOP_POS = 9 * int'(BIT_T) + MID;
	typedef struct packed {
		logic [15:0] h_cnt;
		logic [15:0] e_cnt;
	} mon_t;
	mon_t mon_r, mon_nxt;

	// Frame position counters; they free up at mid stop so a two-stop gap reads as idle
	always_comb
	begin
		mon_nxt = mon_r;
		if (mon_r.h_cnt == 16'(STOP_POS))
			mon_nxt.h_cnt = 16'h0000;
		else if (mon_r.h_cnt != 16'h0000 || !host_serial_in)
			mon_nxt.h_cnt = mon_r.h_cnt + 16'h0001;
		if (mon_r.e_cnt == 16'(STOP_POS))
			mon_nxt.e_cnt = 16'h0000;
		else if (mon_r.e_cnt != 16'h0000 || !echo_serial_out)
			mon_nxt.e_cnt = mon_r.e_cnt + 16'h0001;
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
			mon_r <= '0;
		else
			mon_r <= mon_nxt;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	host_start_a: assert property (mon_r.h_cnt == 16'(MID) |-> !host_serial_in)
		else $error("host start bit not low at its middle");
	host_stop_a: assert property (mon_r.h_cnt == 16'(STOP_POS) |-> host_serial_in)
		else $error("host stop bit not high at its middle");
	echo_start_a: assert property (mon_r.e_cnt == 16'(MID) |-> !echo_serial_out)
		else $error("echo start bit not low at its middle");
	echo_stop_a: assert property (mon_r.e_cnt == 16'(STOP_POS) |-> echo_serial_out)
		else $error("echo stop bit not high at its middle");
	echo_follows_a: assert property (mon_r.h_cnt == 16'(STOP_POS) && !program_sel_n
		|-> ##[1:8] !echo_serial_out)
		else $error("no echo frame after a setup character");
	normal_quiet_a: assert property ($fell(echo_serial_out) && mon_r.e_cnt == 16'h0000
		&& program_sel_n |-> $past(rx_pending))
		else $error("frame sent in normal mode with nothing buffered");
	reset_idle_a: assert property (disable iff (1'b0) !rstn
		|=> echo_serial_out && host_serial_in && !rx_pending)
		else $error("lines not idle after reset");
	enable_held_a: assert property (rstn |-> !enable_n)
		else $error("enable not held low");

	cover property (mon_r.h_cnt == 16'(STOP_POS) && !program_sel_n);
	cover property ($rose(rx_pending));
	cover property ($fell(echo_serial_out) && program_sel_n);
endmodule // modem_setup_command_parser_props

// *** test_modem_setup_command_parser.sv ***
`timescale 1ns/1ps
// Bench joining the host UART end to the setup command parser
module test_modem_setup_command_parser;
	import link_pkg::*;
	logic mclk, rstn, send_valid, setup_req, two_stop, radio_rx_valid;
	logic [7:0] send_data, radio_rx_data, recv_data;
	logic [2:0] radio_rx_addr, link_addr;
	logic send_ready, recv_valid, pending_rise, radio_enable, tone_out, nv_busy;
	logic [1:0] tone_mode;
	logic [3:0] link_chan;
	int err_count, num_checks, rises;
	logic [7:0] rq[$];

	host_link_if link();

	// Short store and bit times keep the run length down
	localparam logic [11:0] BIT_SIM = 12'h010;
	modem_setup_command_parser #(.FIFO_DEPTH(16), .NV_CYC(16'h0014), .BIT_T(BIT_SIM))
		u_modem_setup_command_parser (
		.mclk(mclk), .rstn(rstn), .link(link.modem), .radio_rx_valid(radio_rx_valid),
		.radio_rx_data(radio_rx_data), .radio_rx_addr(radio_rx_addr),
		.radio_enable(radio_enable), .tone_mode(tone_mode), .tone_out(tone_out),
		.link_addr(link_addr), .link_chan(link_chan), .nv_busy(nv_busy));

	host_uart_end #(.BIT_T(BIT_SIM)) u_host_uart_end (.mclk(mclk), .rstn(rstn), .link(link.host),
		.send_valid(send_valid), .send_data(send_data), .send_ready(send_ready),
		.setup_req(setup_req), .two_stop(two_stop), .recv_valid(recv_valid),
		.recv_data(recv_data), .pending_rise(pending_rise));

	modem_setup_command_parser_props #(.BIT_T(BIT_SIM)) u_props (.mclk(mclk), .rstn(rstn),
		.host_serial_in(link.host_serial_in), .echo_serial_out(link.echo_serial_out),
		.program_sel_n(link.program_sel_n), .enable_n(link.enable_n),
		.rx_pending(link.rx_pending));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		if (recv_valid === 1'b1)
			rq.push_back(recv_data);
		if (pending_rise === 1'b1)
			rises++;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Sends a string and judges every echoed character
	task automatic send_echo(input string s);
		int n;
		for (int i = 0; i < s.len(); i++)
		begin
			@(posedge mclk);
			send_valid <= 1'b1;
			send_data <= s[i];
			n = 0;
			do
			begin
				@(posedge mclk);
				n++;
			end
			while (send_ready !== 1'b1 && n < 30000);
			send_valid <= 1'b0;
			if (n >= 30000)
			begin
				err_count++;
				end_sim();
			end
		end
		wait_rx(s.len());
		for (int i = 0; i < s.len(); i++)
			chk(rq.pop_front(), s[i]);
	endtask

	task automatic wait_rx(input int cnt);
		int n;
		n = 0;
		while (rq.size() < cnt && n < 60000)
		begin
			@(posedge mclk);
			n++;
		end
		if (n >= 60000)
		begin
			err_count++;
			end_sim();
		end
	endtask

	task automatic radio_byte(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		radio_rx_valid <= 1'b1;
		radio_rx_addr <= a;
		radio_rx_data <= d;
		@(posedge mclk);
		radio_rx_valid <= 1'b0;
	endtask

	// Builds the text of a command held as packed characters, first character highest
	function automatic string cmd_str(input logic [79:0] v, input int len);
		string s;
		s = "";
		for (int i = len - 1; i >= 0; i--)
			s = $sformatf("%s%c", s, v[i*8 +: 8]);
		return s;
	endfunction

	// Clocks between two changes of the tone output; the first change only aligns
	task automatic tone_half(input logic [11:0] exp);
		logic v;
		int n;
		n = 0;
		for (int k = 0; k < 2; k++)
		begin
			v = tone_out;
			n = 0;
			while (tone_out === v && n < 4000)
			begin
				@(posedge mclk);
				n++;
			end
		end
		chk_cnt(16'(n), {4'h0, exp});
	endtask

	task automatic t_tones;
		send_echo({cmd_str(CARRIER_ONLY_CMD, 6), "\r"});
		chk({6'h00, tone_mode}, 8'h01);
		send_echo({cmd_str(LOW_TONE_CMD, 6), "\r"});
		chk({6'h00, tone_mode}, 8'h02);
		tone_half(LO_HALF_CYC);
		send_echo({cmd_str(HIGH_TONE_CMD, 6), "\r"});
		chk({6'h00, tone_mode}, 8'h03);
		tone_half(HI_HALF_CYC);
		send_echo("\r");
		chk({6'h00, tone_mode}, 8'h00);
	endtask

	task automatic t_reset;
		chk({5'h00, link_addr}, 8'h00);
		chk({6'h00, tone_mode}, 8'h00);
		chk({7'h00, radio_enable}, 8'h01);
	endtask

	task automatic t_address;
		setup_req <= 1'b1;
		two_stop <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({7'h00, radio_enable}, 8'h00);
		send_echo({cmd_str(SET_LINK_ADDRESS_CMD, 4), "7"});
		chk({5'h00, link_addr}, 8'h00);
		send_echo("\r");
		chk({5'h00, link_addr}, 8'h07);
	endtask

	// Stray text must neither act nor linger in front of the next command
	task automatic t_store;
		two_stop <= 1'b0;
		send_echo("Q\r");
		chk({5'h00, link_addr}, 8'h07);
		send_echo({cmd_str(STORE_DEFAULTS_CMD, 10), "\r"});
		wait_rx(1);
		chk(rq.pop_front(), 8'h7e);
		chk({7'h00, nv_busy}, 8'h00);
	endtask

	task automatic t_radio;
		setup_req <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({7'h00, radio_enable}, 8'h01);
		radio_byte(3'h3, 8'h3c);
		repeat (4) @(posedge mclk);
		chk({7'h00, link.rx_pending}, 8'h00);
		radio_byte(3'h7, 8'ha5);
		radio_byte(3'h7, 8'h5a);
		repeat (4) @(posedge mclk);
		chk({7'h00, link.rx_pending}, 8'h01);
		wait_rx(2);
		chk(rq.pop_front(), 8'ha5);
		chk(rq.pop_front(), 8'h5a);
		chk(8'(rises), 8'h01);
		chk({7'h00, link.rx_pending}, 8'h00);
	endtask

	initial
	begin
		rstn = 1'b0;
		send_valid = 1'b0;
		send_data = 8'h00;
		setup_req = 1'b0;
		two_stop = 1'b0;
		radio_rx_valid = 1'b0;
		radio_rx_data = 8'h00;
		radio_rx_addr = 3'h0;
		err_count = 0;
		num_checks = 0;
		rises = 0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_address();
		t_tones();
		t_store();
		t_radio();
		end_sim();
	end
endmodule // test_modem_setup_command_parser
